/* File: src/fws_pkg.sv */
/*
  Constants and command codes for the flash write-status host controller.
  Assumes a parallel NOR flash on asynchronous pins and a 200 MHz host clock.
*/
// Behaviour
// - Host issues command cycles as bus writes
// - Host writes reset after identification or failure; this host writes it only after failure
// - Identification fourth cycle is a read
// - Host enters fast-program mode before fast programs
// - Fast-program mode left only by exit command
// - Host polls status at the program address
// - Host trusts data only after bit 7 true; this host waits for bit 6 to stop toggling and ready high instead
package fws_pkg;
  localparam int FWS_AW = 20;
  localparam int FWS_DW = 16;
  // Controller register offsets
  localparam logic [3:0] FWS_REG_CTRL = 4'h0;
  localparam logic [3:0] FWS_REG_ADDR = 4'h1;
  localparam logic [3:0] FWS_REG_DATA = 4'h2;
  localparam logic [3:0] FWS_REG_STAT = 4'h3;
  localparam logic [3:0] FWS_REG_RDAT = 4'h4;
  localparam logic [3:0] FWS_REG_POLLS = 4'h5;
  // Control field: bits 2:0 command, bit 4 use fast mode
  localparam int FWS_CMD_LSB = 0;
  localparam int FWS_FAST_BIT = 4;
  localparam logic [2:0] FWS_OP_READ = 3'h0;
  localparam logic [2:0] FWS_OP_PROG = 3'h1;
  localparam logic [2:0] FWS_OP_SERASE = 3'h2;
  localparam logic [2:0] FWS_OP_CERASE = 3'h3;
  localparam logic [2:0] FWS_OP_SUSP = 3'h4;
  localparam logic [2:0] FWS_OP_RESUME = 3'h5;
  localparam logic [2:0] FWS_OP_IDENT = 3'h6;
  localparam logic [2:0] FWS_OP_RESET = 3'h7;
  // Status data bit positions
  localparam int FWS_POLL_BIT = 7;
  localparam int FWS_TOG1_BIT = 6;
  localparam int FWS_FAIL_BIT = 5;
  localparam int FWS_TIMER_BIT = 3;
  localparam int FWS_TOG2_BIT = 2;
  // Command bytes
  localparam logic [7:0] FWS_CB_AA = 8'haa;
  localparam logic [7:0] FWS_CB_55 = 8'h55;
  localparam logic [7:0] FWS_CB_PROG = 8'ha0;
  localparam logic [7:0] FWS_CB_ERASE = 8'h80;
  localparam logic [7:0] FWS_CB_CHIP = 8'h10;
  localparam logic [7:0] FWS_CB_SECT = 8'h30;
  localparam logic [7:0] FWS_CB_SUSP = 8'hb0;
  localparam logic [7:0] FWS_CB_IDENT = 8'h90;
  localparam logic [7:0] FWS_CB_RESET = 8'hf0;
  localparam logic [7:0] FWS_CB_BYPASS = 8'h20;
  localparam logic [7:0] FWS_CB_BYPEX = 8'h00;
  localparam logic [FWS_AW-1:0] FWS_UA1 = 20'h00555;
  localparam logic [FWS_AW-1:0] FWS_UA2 = 20'h002aa;
  // Bus timing: strobe low and high phases
  localparam int FWS_CLK_MHZ = 200;
  localparam int FWS_T_STB_NS = 70;
  localparam int FWS_T_GAP_NS = 30;
  localparam int FWS_STB_CYC = (FWS_T_STB_NS * FWS_CLK_MHZ + 999) / 1000;
  localparam int FWS_GAP_CYC = (FWS_T_GAP_NS * FWS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] FWS_RESET_STAT = 4'h0;
endpackage : fws_pkg

/* File: src/fws_bus_cycle.sv */
/*
  One asynchronous flash bus cycle: write or read with strobe timing.
  Assumes data pins resolved outside; read data arrive via two-flop sync.
*/
module fws_bus_cycle
  import fws_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic go_in,
  input wire logic wr_in,
  input wire logic [FWS_AW-1:0] addr_in,
  input wire logic [FWS_DW-1:0] wdata_in,
  input wire logic [FWS_DW-1:0] dq_in,
  output logic [FWS_AW-1:0] addr_out,
  output logic [FWS_DW-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out,
  output logic busy_out,
  output logic done_out,
  output logic [FWS_DW-1:0] rdata_out
);
  typedef enum logic [1:0] {FWS_BC_IDLE, FWS_BC_SETUP, FWS_BC_STB, FWS_BC_GAP} fws_bc_st_t;
  typedef struct packed {
    fws_bc_st_t st;
    logic [7:0] cnt;
    logic wr;
    logic [FWS_AW-1:0] addr;
    logic [FWS_DW-1:0] wd;
    logic [FWS_DW-1:0] rd;
    logic [FWS_DW-1:0] s1;
    logic [FWS_DW-1:0] s2;
    logic done;
  } fws_bc_t;
  fws_bc_t q_r, q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    q_nxt.s1 = dq_in;
    q_nxt.s2 = q_r.s1;
    case (q_r.st)
      FWS_BC_IDLE: begin
        if (go_in) begin
          q_nxt.st = FWS_BC_SETUP;
          q_nxt.wr = wr_in;
          q_nxt.addr = addr_in;
          q_nxt.wd = wdata_in;
        end
      end
      FWS_BC_SETUP: begin
        // One clock of setup so the flash never latches a moving address
        q_nxt.st = FWS_BC_STB;
        q_nxt.cnt = 8'(FWS_STB_CYC + 2);
      end
      FWS_BC_STB: begin
        // Strobe held long enough that the synchroniser settles before capture
        if (q_r.cnt == 8'h00) begin
          q_nxt.st = FWS_BC_GAP;
          q_nxt.cnt = 8'(FWS_GAP_CYC);
          q_nxt.rd = q_r.s2;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      FWS_BC_GAP: begin
        if (q_r.cnt == 8'h00) begin
          q_nxt.st = FWS_BC_IDLE;
          q_nxt.done = 1'b1;
        end else begin
          q_nxt.cnt = q_r.cnt - 8'h01;
        end
      end
      default: q_nxt.st = FWS_BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Address set before the strobe falls; data held past its rise
  assign addr_out = q_r.addr;
  assign dq_out = q_r.wd;
  assign dq_oe_n_out = !(q_r.wr && q_r.st != FWS_BC_IDLE);
  assign ce_n_out = (q_r.st != FWS_BC_STB);
  assign we_n_out = !(q_r.st == FWS_BC_STB && q_r.wr);
  assign oe_n_out = !(q_r.st == FWS_BC_STB && !q_r.wr);
  assign busy_out = (q_r.st != FWS_BC_IDLE);
  assign done_out = q_r.done;
  assign rdata_out = q_r.rd;
endmodule : fws_bus_cycle

/* File: src/fws_host.sv */
/*
  Host controller that runs flash command sequences and polls write status.
  Assumes a software port on the same clock and flash pins on the outside.
*/
module fws_host
  import fws_pkg::*;
#(
  parameter int POLL_MAX = 1000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [FWS_DW-1:0] dq_in,
  input wire logic ready_busy_n_in,
  output logic [FWS_AW-1:0] flash_addr_out,
  output logic [FWS_DW-1:0] dq_out,
  output logic dq_oe_n_out,
  output logic ce_n_out,
  output logic we_n_out,
  output logic oe_n_out
);
  typedef enum logic [3:0] {
    FWS_IDLE, FWS_SEQ, FWS_POLL1, FWS_POLL2, FWS_CHECK, FWS_FINAL, FWS_FIN_RST
  } fws_st_t;
  typedef struct packed {
    fws_st_t st;
    logic [2:0] op;
    logic fast;
    logic bypass;
    logic [2:0] step;
    logic [FWS_AW-1:0] addr;
    logic [FWS_DW-1:0] data;
    logic [FWS_DW-1:0] rdat;
    logic [FWS_DW-1:0] prev;
    logic [31:0] polls;
    logic busy;
    logic done;
    logic fail;
    logic rb1;
    logic rb2;
    logic [31:0] rout;
  } fws_host_t;
  fws_host_t q_r, q_nxt;

  logic cyc_go, cyc_wr, cyc_busy, cyc_done;
  logic [FWS_AW-1:0] cyc_addr;
  logic [FWS_DW-1:0] cyc_wd, cyc_rd;

  fws_bus_cycle u_cyc (
    .clk_in(clk_in), .rst_in(rst_in), .go_in(cyc_go), .wr_in(cyc_wr),
    .addr_in(cyc_addr), .wdata_in(cyc_wd), .dq_in(dq_in),
    .addr_out(flash_addr_out), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out),
    .ce_n_out(ce_n_out), .we_n_out(we_n_out), .oe_n_out(oe_n_out),
    .busy_out(cyc_busy), .done_out(cyc_done), .rdata_out(cyc_rd)
  );

  // Sequence table: returns {is_last, is_read, addr, data} for each step
  function automatic logic [37:0] fws_step(input logic [2:0] op, input logic [2:0] s,
      input logic byp, input logic [FWS_AW-1:0] a, input logic [FWS_DW-1:0] d);
    logic [FWS_AW-1:0] ua;
    logic [7:0] cb;
    logic last;
    logic rd;
    logic [FWS_DW-1:0] dd;
    ua = (s[0] == 1'b0) ? FWS_UA1 : FWS_UA2;
    cb = (s[0] == 1'b0) ? FWS_CB_AA : FWS_CB_55;
    last = 1'b0;
    rd = 1'b0;
    dd = {8'h00, cb};
    case (op)
      FWS_OP_READ: begin
        last = 1'b1; rd = 1'b1; ua = a;
      end
      FWS_OP_RESET, FWS_OP_SUSP, FWS_OP_RESUME: begin
        last = 1'b1;
        dd = {8'h00, (op == FWS_OP_RESET) ? FWS_CB_RESET :
          (op == FWS_OP_SUSP) ? FWS_CB_SUSP : FWS_CB_SECT};
      end
      FWS_OP_PROG: begin
        if (byp) begin
          // Fast mode: two cycles only
          if (s == 3'h0) dd = {8'h00, FWS_CB_PROG};
          else begin last = 1'b1; ua = a; dd = d; end
        end else if (s == 3'h2) begin
          ua = FWS_UA1; dd = {8'h00, FWS_CB_PROG};
        end else if (s == 3'h3) begin
          last = 1'b1; ua = a; dd = d;
        end
      end
      FWS_OP_IDENT: begin
        if (s == 3'h2) begin ua = FWS_UA1; dd = {8'h00, FWS_CB_IDENT}; end
        else if (s == 3'h3) begin last = 1'b1; rd = 1'b1; ua = a; end
      end
      default: begin
        // Erase: six cycles; last carries sector select or chip code
        if (s == 3'h2) begin ua = FWS_UA1; dd = {8'h00, FWS_CB_ERASE}; end
        else if (s == 3'h3) begin ua = FWS_UA1; dd = {8'h00, FWS_CB_AA}; end
        else if (s == 3'h4) begin ua = FWS_UA2; dd = {8'h00, FWS_CB_55}; end
        else if (s == 3'h5) begin
          last = 1'b1;
          if (op == FWS_OP_SERASE) begin
            ua = {1'b0, a[18:12], 12'h000}; dd = {8'h00, FWS_CB_SECT};
          end else begin
            ua = FWS_UA1; dd = {8'h00, FWS_CB_CHIP};
          end
        end
      end
    endcase
    fws_step = {last, rd, ua, dd};
  endfunction : fws_step

  logic [37:0] cur;
  always_comb cur = fws_step(q_r.op, q_r.step, q_r.bypass, q_r.addr, q_r.data);

  always_comb begin
    q_nxt = q_r;
    q_nxt.rb1 = ready_busy_n_in;
    q_nxt.rb2 = q_r.rb1;
    cyc_go = 1'b0;
    cyc_wr = !cur[36];
    cyc_addr = cur[35:16];
    cyc_wd = cur[15:0];
    if (reg_wr_in) begin
      case (reg_addr_in)
        FWS_REG_ADDR: q_nxt.addr = reg_wdata_in[FWS_AW-1:0];
        FWS_REG_DATA: q_nxt.data = reg_wdata_in[FWS_DW-1:0];
        FWS_REG_CTRL: begin
          if (q_r.st == FWS_IDLE) begin
            q_nxt.op = reg_wdata_in[FWS_CMD_LSB +: 3];
            q_nxt.fast = reg_wdata_in[FWS_FAST_BIT];
            q_nxt.step = 3'h0;
            q_nxt.st = FWS_SEQ;
            q_nxt.busy = 1'b1;
            q_nxt.done = 1'b0;
            q_nxt.fail = 1'b0;
            q_nxt.polls = 32'h0;
          end
        end
        default: ;
      endcase
    end
    case (q_r.st)
      FWS_IDLE: ;
      FWS_SEQ: begin
        cyc_go = !cyc_busy && !cyc_done;
        if (q_r.fast && !q_r.bypass && q_r.op == FWS_OP_PROG) begin
          // Enter fast mode with the three-cycle bypass command first
          cyc_addr = (q_r.step[0]) ? FWS_UA2 : FWS_UA1;
          cyc_wd = {8'h00, (q_r.step == 3'h2) ? FWS_CB_BYPASS :
            (q_r.step[0] ? FWS_CB_55 : FWS_CB_AA)};
          cyc_wr = 1'b1;
          if (cyc_done) begin
            q_nxt.step = q_r.step + 3'h1;
            if (q_r.step == 3'h2) begin q_nxt.bypass = 1'b1; q_nxt.step = 3'h0; end
          end
        end else if (!q_r.fast && q_r.bypass) begin
          // Leaving fast mode needs its own exit pair
          cyc_addr = '0;
          cyc_wd = {8'h00, q_r.step[0] ? FWS_CB_BYPEX : FWS_CB_IDENT};
          cyc_wr = 1'b1;
          if (cyc_done) begin
            q_nxt.step = q_r.step + 3'h1;
            if (q_r.step[0]) begin q_nxt.bypass = 1'b0; q_nxt.step = 3'h0; end
          end
        end else if (cyc_done) begin
          q_nxt.step = q_r.step + 3'h1;
          if (cur[37]) begin
            q_nxt.rdat = cyc_rd;
            q_nxt.step = 3'h0;
            if (q_r.op == FWS_OP_PROG || q_r.op == FWS_OP_SERASE ||
                q_r.op == FWS_OP_CERASE) q_nxt.st = FWS_POLL1;
            else begin q_nxt.st = FWS_IDLE; q_nxt.busy = 1'b0; q_nxt.done = 1'b1; end
          end
        end
      end
      FWS_POLL1, FWS_POLL2, FWS_FINAL: begin
        // Poll at the target address so bit 7 is meaningful
        cyc_wr = 1'b0;
        cyc_addr = q_r.addr;
        cyc_go = !cyc_busy && !cyc_done;
        if (cyc_done) begin
          q_nxt.prev = q_r.rdat;
          q_nxt.rdat = cyc_rd;
          q_nxt.polls = q_r.polls + 32'h1;
          q_nxt.st = (q_r.st == FWS_FINAL) ? FWS_IDLE :
            (q_r.st == FWS_POLL1) ? FWS_POLL2 : FWS_CHECK;
          if (q_r.st == FWS_FINAL) begin
            // Whole word only trusted on a read after bit 6 stopped toggling and ready went high
            q_nxt.busy = 1'b0;
            q_nxt.done = 1'b1;
          end
        end
      end
      FWS_CHECK: begin
        // Toggle bit stopped means the algorithm finished
        if (q_r.rdat[FWS_TOG1_BIT] == q_r.prev[FWS_TOG1_BIT] && q_r.rb2) begin
          q_nxt.st = FWS_FINAL;
        end else if (q_r.rdat[FWS_FAIL_BIT] || q_r.polls >= 32'(POLL_MAX)) begin
          q_nxt.fail = 1'b1;
          q_nxt.st = FWS_FIN_RST;
        end else begin
          q_nxt.st = FWS_POLL2;
        end
      end
      FWS_FIN_RST: begin
        // Failure leaves status output until reset is written
        cyc_wr = 1'b1;
        cyc_addr = '0;
        cyc_wd = {8'h00, FWS_CB_RESET};
        cyc_go = !cyc_busy && !cyc_done;
        if (cyc_done) begin
          // Fast mode survives a reset command; only the exit pair leaves it
          q_nxt.st = FWS_IDLE; q_nxt.busy = 1'b0; q_nxt.done = 1'b1;
        end
      end
      default: q_nxt.st = FWS_IDLE;
    endcase
    q_nxt.rout = 32'h0;
    if (reg_rd_in) begin
      case (reg_addr_in)
        FWS_REG_CTRL: q_nxt.rout = {27'h0, q_r.fast, 1'b0, q_r.op};
        FWS_REG_ADDR: q_nxt.rout = {12'h0, q_r.addr};
        FWS_REG_DATA: q_nxt.rout = {16'h0, q_r.data};
        FWS_REG_STAT: q_nxt.rout = {27'h0, q_r.rb2, q_r.bypass, q_r.fail, q_r.done, q_r.busy};
        FWS_REG_RDAT: q_nxt.rout = {16'h0, q_r.rdat};
        FWS_REG_POLLS: q_nxt.rout = q_r.polls;
        default: q_nxt.rout = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      q_r <= '0;
      q_r.rb1 <= 1'b1;
      q_r.rb2 <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata_out = q_r.rout;
endmodule : fws_host

/* File: testbench/fws_host_properties.sv */
/*
  Concurrent checks on the fws_host flash pins and register port.
  Assumes one clock with a synchronous active-high reset; bound below.
*/
module fws_host_properties
  import fws_pkg::*;
#(
  parameter int POLL_MAX = 1000000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic [FWS_DW-1:0] dq_in,
  input wire logic ready_busy_n_in,
  input wire logic [FWS_AW-1:0] flash_addr_out,
  input wire logic [FWS_DW-1:0] dq_out,
  input wire logic dq_oe_n_out,
  input wire logic ce_n_out,
  input wire logic we_n_out,
  input wire logic oe_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] low_r;
  logic [7:0] low_nxt;
  always_comb low_nxt = we_n_out ? 8'h00 : low_r + 8'h01;
  always_ff @(posedge clk_in) low_r <= rst_in ? 8'h00 : low_nxt;
  idle_after_reset_a: assert property ($fell(rst_in) |-> ce_n_out && we_n_out && oe_n_out)
    else $error("strobes active after reset");
  strobe_excl_a: assert property (!(!we_n_out && !oe_n_out))
    else $error("write and read strobes low together");
  we_select_a: assert property (!we_n_out |-> !ce_n_out)
    else $error("write strobe without chip select");
  oe_select_a: assert property (!oe_n_out |-> !ce_n_out && dq_oe_n_out)
    else $error("read strobe without select or with host driving");
  drive_write_a: assert property (!dq_oe_n_out |-> oe_n_out)
    else $error("host drives data during a read");
  addr_setup_a: assert property ($fell(ce_n_out) |->
    $stable(flash_addr_out) && $stable(dq_out))
    else $error("address or data moved as chip select fell");
  addr_hold_a: assert property (!we_n_out && !$past(we_n_out) |->
    $stable(flash_addr_out) && $stable(dq_out))
    else $error("address or data moved under write strobe");
  wr_width_a: assert property ($rose(we_n_out) |-> low_r >= FWS_STB_CYC)
    else $error("write strobe too short");
  wr_gap_a: assert property ($rose(we_n_out) |-> we_n_out [*6])
    else $error("write recovery gap too short");
  rd_width_a: assert property ($fell(oe_n_out) |-> !oe_n_out [*8])
    else $error("read strobe too short");
  rdata_quiet_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside its cycle");
  cover property ($rose(we_n_out));
  cover property ($fell(oe_n_out));
  cover property ($rose(ready_busy_n_in));
endmodule : fws_host_properties

bind fws_host fws_host_properties #(.POLL_MAX(POLL_MAX)) u_props (.*);

/* File: testbench/fws_flash_model.sv */
/*
  Behavioural flash: unlock decode, program, identify and write status.
  Assumes active-low strobes and a data bus resolved by the bench.
*/
module fws_flash_model
  import fws_pkg::*;
#(
  parameter logic [15:0] ID_WORD = 16'h005a, // Arbitrary identity value
  parameter int PROG_NS = 600
) (
  input wire logic ce_n_in,
  input wire logic we_n_in,
  input wire logic oe_n_in,
  input wire logic [FWS_AW-1:0] addr_in,
  input wire logic [FWS_DW-1:0] dq_in,
  input wire logic fail_mode_in,
  output logic [FWS_DW-1:0] dq_out,
  output logic ready_busy_n_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [256];
  logic [15:0] pv = 16'h0;
  logic [15:0] rv = 16'h0;
  logic [19:0] la = 20'h0;
  logic [7:0] pa = 8'h0;
  logic act = 1'b0, busy = 1'b0, tog = 1'b0, fl = 1'b0, ident = 1'b0, prog = 1'b0;
  logic byp = 1'b0, bx = 1'b0, ers = 1'b0;
  int st = 0;
  int resets = 0;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  task automatic cmd(input logic [19:0] a, input logic [15:0] d);
    if (busy) begin
      if (d[7:0] == FWS_CB_RESET && fl) begin
        busy = 1'b0;
        fl = 1'b0;
        resets++;
      end
    end else if (prog) begin
      prog = 1'b0;
      pa = a[7:0];
      pv = d;
      busy = 1'b1;
      fork
        begin
          #(PROG_NS);
          if (fail_mode_in) fl = 1'b1;
          else begin
            mem[pa] = pv;
            busy = 1'b0;
          end
        end
      join_none
    end else if (byp) begin
      // Bypass mode decodes only its program prefix and its exit pair
      if (bx) begin
        byp = (d[7:0] != FWS_CB_BYPEX);
        bx = 1'b0;
      end else begin
        prog = (d[7:0] == FWS_CB_PROG);
        bx = (d[7:0] == FWS_CB_IDENT);
      end
    end else if (d[7:0] == FWS_CB_RESET) begin
      ident = 1'b0;
      st = 0;
      resets++;
    end else begin
      case (st)
        0: st = (a[10:0] == FWS_UA1[10:0] && d[7:0] == FWS_CB_AA) ? 1 : 0;
        1: st = (a[10:0] == FWS_UA2[10:0] && d[7:0] == FWS_CB_55) ? 2 : 0;
        default: begin
          st = 0;
          if (ers && (d[7:0] == FWS_CB_SECT || d[7:0] == FWS_CB_CHIP)) begin
            // Erase leaves all ones, so the polled complement reads low
            pv = 16'hffff;
            busy = 1'b1;
            fork
              begin
                #(PROG_NS);
                foreach (mem[i]) mem[i] = 16'hffff;
                busy = 1'b0;
              end
            join_none
          end
          ers = (d[7:0] == FWS_CB_ERASE);
          prog = (d[7:0] == FWS_CB_PROG);
          ident = ident | (d[7:0] == FWS_CB_IDENT);
          byp = (d[7:0] == FWS_CB_BYPASS);
        end
      endcase
    end
  endtask : cmd
  always @(negedge we_n_in or negedge ce_n_in) begin
    if (!we_n_in && !ce_n_in) begin
      la = addr_in;
      act = 1'b1;
    end
  end
  always @(posedge we_n_in or posedge ce_n_in) begin
    if (act) begin
      act = 1'b0;
      cmd(la, dq_in);
    end
  end
  // Paced by the read strobe only, so one read never toggles twice
  always @(negedge oe_n_in) begin
    #0.1;
    if (!ce_n_in) begin
      if (busy) begin
        tog = ~tog;
        rv = {8'h00, ~pv[7], tog, fl, 5'h00};
      end else begin
        rv = ident ? ID_WORD : mem[addr_in[7:0]];
      end
    end
  end
  // Released bus shows the inverse so a stale word cannot pass
  assign dq_out = (!oe_n_in && !ce_n_in) ? rv : ~rv;
  assign ready_busy_n_out = !busy;
endmodule : fws_flash_model

/* File: testbench/test_fws_host.sv */
/*
  Self-checking bench for fws_host against the behavioural flash model.
  Assumes the register map and op codes of fws_pkg.
*/
module test_fws_host
  import fws_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", n, e, s); end end
  localparam logic [15:0] ID_W = 16'h005a; // Arbitrary identity value
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [3:0] ra = 4'h0;
  logic [31:0] wd = 32'h0;
  logic wr = 1'b0, rd = 1'b0, fail_mode = 1'b0;
  logic [31:0] rdata;
  logic [15:0] hdq, fdq, bus;
  logic [19:0] fa;
  logic rbn, doe, ce, we, oe;
  int fails = 0;
  int check_count = 0;
  assign bus = doe ? fdq : hdq;
  always #2.5 clk_in = ~clk_in;
  fws_host #(.POLL_MAX(20)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(ra),
    .reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .dq_in(bus),
    .ready_busy_n_in(rbn), .flash_addr_out(fa), .dq_out(hdq), .dq_oe_n_out(doe),
    .ce_n_out(ce), .we_n_out(we), .oe_n_out(oe));
  fws_flash_model #(.ID_WORD(ID_W)) u_flash (.ce_n_in(ce), .we_n_in(we), .oe_n_in(oe),
    .addr_in(fa), .dq_in(bus), .fail_mode_in(fail_mode), .dq_out(fdq),
    .ready_busy_n_out(rbn));
  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rreg
  // Start an op and poll status until done; a lost op ends the run
  task automatic run(input logic [2:0] op, input logic fast, output logic [31:0] s);
    int n;
    wreg(FWS_REG_CTRL, {27'h0, fast, 1'b0, op});
    n = 0;
    s = 32'h0;
    while (s[1] !== 1'b1 && n < 3000) begin
      rreg(FWS_REG_STAT, s);
      n++;
    end
    if (n == 3000) begin
      fails++;
      print_verdict();
    end
  endtask : run
  task automatic t_reset();
    logic [31:0] d;
    rreg(FWS_REG_STAT, d);
    `CHK("stat", FWS_RESET_STAT, d[3:0])
    rreg(4'hf, d);
    `CHK("unmapped", 32'h0, d)
  endtask : t_reset
  task automatic t_read();
    logic [31:0] s, d;
    u_flash.mem[8'h12] = 16'h1234;
    wreg(FWS_REG_ADDR, 32'h12);
    run(FWS_OP_READ, 1'b0, s);
    rreg(FWS_REG_RDAT, d);
    `CHK("array read", 32'h1234, d)
  endtask : t_read
  // Reset written mid-program must be refused while the poll runs on
  task automatic t_prog();
    logic [31:0] s, d;
    wreg(FWS_REG_ADDR, 32'h34);
    wreg(FWS_REG_DATA, 32'h5a3c);
    wreg(FWS_REG_CTRL, {29'h0, FWS_OP_PROG});
    repeat (120) @(posedge clk_in);
    rreg(FWS_REG_STAT, s);
    `CHK("busy", 1'b1, s[0])
    `CHK("ready low", 1'b0, s[4])
    run(FWS_OP_RESET, 1'b0, s);
    `CHK("no fail", 1'b0, s[2])
    `CHK("ready high", 1'b1, s[4])
    `CHK("refused", 0, u_flash.resets)
    `CHK("programmed", 16'h5a3c, u_flash.mem[8'h34])
    rreg(FWS_REG_POLLS, d);
    `CHK("polls", 1'b1, d > 32'h1)
  endtask : t_prog
  task automatic t_fail();
    logic [31:0] s;
    fail_mode = 1'b1;
    wreg(FWS_REG_ADDR, 32'h56);
    wreg(FWS_REG_DATA, 32'h0001);
    run(FWS_OP_PROG, 1'b0, s);
    `CHK("fail", 1'b1, s[2])
    `CHK("reset sent", 1, u_flash.resets)
    `CHK("untouched", 16'hffff, u_flash.mem[8'h56])
    fail_mode = 1'b0;
  endtask : t_fail
  // Fast mode stays on after its program until an op runs with the bit clear
  task automatic t_fast();
    logic [31:0] s, d;
    wreg(FWS_REG_ADDR, 32'h78);
    wreg(FWS_REG_DATA, 32'h00c3);
    run(FWS_OP_PROG, 1'b1, s);
    `CHK("fast active", 1'b1, s[3])
    `CHK("model bypass", 1'b1, u_flash.byp)
    `CHK("fast programmed", 16'h00c3, u_flash.mem[8'h78])
    run(FWS_OP_READ, 1'b0, s);
    `CHK("fast left", 1'b0, s[3])
    `CHK("model left", 1'b0, u_flash.byp)
    rreg(FWS_REG_RDAT, d);
    `CHK("fast read", 32'h00c3, d)
  endtask : t_fast
  task automatic t_erase();
    logic [31:0] s;
    wreg(FWS_REG_ADDR, 32'h34055);
    run(FWS_OP_SERASE, 1'b0, s);
    `CHK("sector", 20'h34000, u_flash.la)
    `CHK("erased", 16'hffff, u_flash.mem[8'h34])
    `CHK("erase ok", 1'b0, s[2])
    u_flash.mem[8'h20] = 16'h0000;
    run(FWS_OP_CERASE, 1'b0, s);
    `CHK("chip erased", 16'hffff, u_flash.mem[8'h20])
    run(FWS_OP_RESUME, 1'b0, s);
    `CHK("resume ignored", 1'b1, u_flash.ready_busy_n_out)
  endtask : t_erase
  task automatic t_ident();
    logic [31:0] s, d;
    wreg(FWS_REG_ADDR, 32'h0);
    run(FWS_OP_IDENT, 1'b0, s);
    rreg(FWS_REG_RDAT, d);
    `CHK("ident", {16'h0, ID_W}, d)
    run(FWS_OP_RESET, 1'b0, s);
    wreg(FWS_REG_ADDR, 32'h12);
    run(FWS_OP_READ, 1'b0, s);
    rreg(FWS_REG_RDAT, d);
    `CHK("array after reset", 32'h1234, d)
  endtask : t_ident
  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_read();
    t_prog();
    t_fail();
    t_fast();
    t_ident();
    t_erase();
    print_verdict();
  end
endmodule : test_fws_host
